// ===== lss_params.svh
// Constants for the sixteen-stage LED sink shift and latch block.
// Contract
// - Shift rising edge advances all sixteen stages.
// - Serial data is stored inverted on entry.
// - Latch rising edge copies all shift stages.
// - Shift and latch clocks act independently, rising.
// - Each bit has shift and latch flops.
// - LED sink outputs are open drain only.
// - Cascade output shows the sixteenth shift stage.
// - Tied clocks latch the pre-shift contents.
// - Init sets registers, floats sinks, cascade low.
// - Output off floats all sinks, cascade unchanged.
// - Output off never disturbs shifting.
`ifndef LSS_PARAMS_SVH
`define LSS_PARAMS_SVH

`define LSS_STAGES      16
`define LSS_LAST_STAGE  15
`define LSS_SHIFT_RST   16'hFFFF
`define LSS_LATCH_RST   16'hFFFF
`define LSS_SINK_OFF    16'hFFFF
`define LSS_PINS        5
`define LSS_PIN_RST     5'h0
`define LSS_PIN_SHIFT   0
`define LSS_PIN_LATCH   1
`define LSS_PIN_DATA    2
`define LSS_PIN_INIT_N  3
`define LSS_PIN_OFF     4

`endif

// ===== lss_pkg.sv
// Types shared by the LED sink shift and latch block.
`include "lss_params.svh"

package lss_pkg;

  // Core state: shift stages, latch stages and registered pin drives.
  typedef struct packed {
    logic [`LSS_STAGES-1:0] shift;
    logic [`LSS_STAGES-1:0] latch;
    logic [`LSS_STAGES-1:0] oe_n;
    logic                   sink;
    logic                   casc;
  } lss_core_t;

  // Pin synchroniser state.
  typedef struct packed {
    logic [`LSS_PINS-1:0] meta;
    logic [`LSS_PINS-1:0] stable;
    logic [`LSS_PINS-1:0] prev;
    logic                 shift_rise;
    logic                 latch_rise;
  } lss_sync_t;

endpackage

// ===== lss_pins_if.sv
// Synchronised pin levels and clock edge pulses passed to the core.
`timescale 1ns/1ps

interface lss_pins_if;
  logic shift_rise;
  logic latch_rise;
  logic data_in;
  logic init_act;
  logic out_off;

  modport src (output shift_rise, output latch_rise, output data_in, output init_act,
               output out_off);
  modport dst (input shift_rise, input latch_rise, input data_in, input init_act,
               input out_off);
endinterface

// ===== lss_pin_sync.sv
// Two-flop synchroniser and rising edge finder for the host pins.
`timescale 1ns/1ps
`include "lss_params.svh"

module lss_pin_sync (
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  input  wire logic [`LSS_PINS-1:0] pins,
  lss_pins_if.src                   sync
);

  lss_pkg::lss_sync_t st_q;
  lss_pkg::lss_sync_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state. The first stage is only copied into the second; edges are
  // found on the second stage so a metastable level never reaches logic.
  always_comb begin
    st_d            = st_q;
    st_d.meta       = pins;
    st_d.stable     = st_q.meta;
    st_d.prev       = st_q.stable;
    st_d.shift_rise = st_q.stable[`LSS_PIN_SHIFT] & ~st_q.prev[`LSS_PIN_SHIFT];
    st_d.latch_rise = st_q.stable[`LSS_PIN_LATCH] & ~st_q.prev[`LSS_PIN_LATCH];
  end

  // Register the whole state.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{meta: `LSS_PIN_RST, stable: `LSS_PIN_RST, prev: `LSS_PIN_RST,
                shift_rise: 1'b0, latch_rise: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hand the synchronised values to the core; init pin is active low.
  assign sync.shift_rise = st_q.shift_rise;
  assign sync.latch_rise = st_q.latch_rise;
  assign sync.data_in    = st_q.stable[`LSS_PIN_DATA];
  assign sync.init_act   = ~st_q.stable[`LSS_PIN_INIT_N];
  assign sync.out_off    = st_q.stable[`LSS_PIN_OFF];

  // An edge pulse follows a low then high second stage by one cycle.
  chk_edge_pulse_shape: assert property (@(posedge clock) disable iff (!rst_b)
    st_q.shift_rise |-> !$past(st_q.shift_rise))
    else $error("shift edge pulse lasted more than one cycle");

endmodule

// ===== lss_led_sink.sv
// Sixteen-stage serial shift register with latch driving open-drain LED sinks.
`timescale 1ns/1ps
`include "lss_params.svh"

module lss_led_sink (
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire logic                   shift_clk,
  input  wire logic                   latch_clk,
  input  wire logic                   shift_in,
  input  wire logic                   init_n,
  input  wire logic                   output_on,
  output logic [`LSS_STAGES-1:0]      led_sink_o,
  output logic [`LSS_STAGES-1:0]      led_sink_oe_n,
  output logic                        cascade_out
);

  lss_pins_if         pin_bus ();
  lss_pkg::lss_core_t st_q;
  lss_pkg::lss_core_t st_d;
  logic               sink_off;

  ////////////////////////////////////////////////////////////////////////////
  // All host pins come from outside this clock and are synchronised first.
  lss_pin_sync u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .pins  ({output_on, init_n, shift_in, latch_clk, shift_clk}),
    .sync  (pin_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state. Each bit owns a shift flop and a separate latch flop, and the
  // latch always reads the shift value from before this cycle's shift, so
  // clocks tied together give the one-edge delay.
  always_comb begin
    st_d     = st_q;
    sink_off = pin_bus.init_act | pin_bus.out_off;
    if (pin_bus.init_act) begin
      // Init overrides everything; clocks and data are ignored.
      st_d.shift = `LSS_SHIFT_RST;
      st_d.latch = `LSS_LATCH_RST;
    end else begin
      if (pin_bus.shift_rise) begin
        // Stage 0 takes the inverted serial bit: one means sink off.
        st_d.shift = {st_q.shift[`LSS_STAGES-2:0], ~pin_bus.data_in};
      end
      if (pin_bus.latch_rise) begin
        st_d.latch = st_q.shift;
      end
    end
    // A low latch bit enables the sink; never a high drive on these pins.
    st_d.oe_n = sink_off ? `LSS_SINK_OFF : st_d.latch;
    st_d.sink = 1'b0;
    // Cascade carries stage sixteen back in host polarity for the next part.
    st_d.casc = ~st_d.shift[`LSS_LAST_STAGE];
  end

  // Register the whole state; reset sets both register banks.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{shift: `LSS_SHIFT_RST, latch: `LSS_LATCH_RST, oe_n: `LSS_SINK_OFF,
                sink: 1'b0, casc: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from flops.
  assign led_sink_o    = {`LSS_STAGES{st_q.sink}};
  assign led_sink_oe_n = st_q.oe_n;
  assign cascade_out   = st_q.casc;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_shift_req;
    pin_bus.shift_rise && !pin_bus.init_act;
  endsequence

  sequence s_latch_req;
    pin_bus.latch_rise && !pin_bus.init_act;
  endsequence

  sequence s_both_req;
    s_shift_req and s_latch_req;
  endsequence

  chk_shift_advance: assert property (
    s_shift_req |=> st_q.shift[`LSS_STAGES-1:1] == $past(st_q.shift[`LSS_STAGES-2:0]))
    else $error("shift stages did not advance by one");

  chk_data_invert: assert property (
    s_shift_req |=> st_q.shift[0] == !$past(pin_bus.data_in))
    else $error("first stage did not take inverted data");

  chk_latch_copy: assert property (
    s_latch_req |=> st_q.latch == $past(st_q.shift))
    else $error("latch did not copy the shift register");

  chk_shift_hold: assert property (
    !pin_bus.shift_rise && !pin_bus.init_act |=> $stable(st_q.shift))
    else $error("shift register moved without a shift edge");

  chk_latch_hold: assert property (
    !pin_bus.latch_rise && !pin_bus.init_act |=> $stable(st_q.latch))
    else $error("latch changed without a latch edge");

  chk_open_drain: assert property (
    led_sink_o == '0)
    else $error("sink output drove high");

  chk_cascade_stage: assert property (
    cascade_out == !st_q.shift[`LSS_LAST_STAGE])
    else $error("cascade did not follow the last stage");

  chk_tied_clocks: assert property (
    s_both_req ##1 1'b1 |=> led_sink_oe_n == $past(st_q.shift, 2)
                            || $past(pin_bus.out_off))
    else $error("tied clocks did not latch pre-shift contents");

  chk_init_clear: assert property (
    pin_bus.init_act |=> st_q.shift == `LSS_SHIFT_RST && led_sink_oe_n == `LSS_SINK_OFF
                         && !cascade_out)
    else $error("init did not set registers and float sinks");

  chk_output_off: assert property (
    pin_bus.out_off |=> led_sink_oe_n == `LSS_SINK_OFF
                        && cascade_out == !st_q.shift[`LSS_LAST_STAGE])
    else $error("output off did not float the sinks");

  chk_off_shifts: assert property (
    s_shift_req and pin_bus.out_off |=>
      st_q.shift[`LSS_STAGES-1:1] == $past(st_q.shift[`LSS_STAGES-2:0]))
    else $error("output off disturbed shifting");

  chk_sink_follow: assert property (
    !pin_bus.init_act && !pin_bus.out_off |=> led_sink_oe_n == st_q.latch)
    else $error("sinks did not show the latched state");

endmodule

// ===== lss_host_model.sv
// Host controller model driving the serial, clock and control pins.
`timescale 1ns/1ps

module lss_host_model (
  input  wire logic clock,
  output logic      shift_clk,
  output logic      latch_clk,
  output logic      shift_in,
  output logic      init_n,
  output logic      output_on
);
  // Clocks idle low, so no pin edge reaches the block until a task runs.
  initial begin
    shift_clk = 1'h0;
    latch_clk = 1'h0;
    shift_in  = 1'h0;
    init_n    = 1'h1;
    output_on = 1'h0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One 360 ns host clock period; data is held well before and after the rise.
  task automatic pulse(input logic s, input logic l, input logic b);
    @(posedge clock);
    shift_in <= b;
    repeat (4) @(posedge clock);
    shift_clk <= s;
    latch_clk <= l;
    repeat (4) @(posedge clock);
    shift_clk <= 1'h0;
    latch_clk <= 1'h0;
  endtask

  // Level pins change only on a rising edge of the system clock.
  task automatic set_pins(input logic off, input logic init);
    @(posedge clock);
    output_on <= off;
    init_n    <= init;
  endtask
endmodule

// ===== led_sink_shift_latch_16_tb.sv
// Self-checking bench for the LED sink shift and latch block.
`timescale 1ns/1ps
`include "lss_params.svh"

module led_sink_shift_latch_16_tb;
  logic                   clock = 1'h0;
  logic                   rst_b = 1'h0;
  logic                   shift_clk;
  logic                   latch_clk;
  logic                   shift_in;
  logic                   init_n;
  logic                   output_on;
  logic [`LSS_STAGES-1:0] led_sink_o;
  logic [`LSS_STAGES-1:0] led_sink_oe_n;
  logic                   cascade_out;
  logic [15:0]            sr_exp = 16'hFFFF;
  logic [15:0]            lat_exp = 16'hFFFF;
  int                     mismatches = 0;
  int                     total_checks = 0;
  int                     cycles = 0;

  // 25 MHz system clock.
  always #20 clock = ~clock;

  lss_host_model host (.clock(clock), .shift_clk(shift_clk), .latch_clk(latch_clk),
                       .shift_in(shift_in), .init_n(init_n), .output_on(output_on));

  lss_led_sink uut (.clock(clock), .rst_b(rst_b), .shift_clk(shift_clk),
                    .latch_clk(latch_clk), .shift_in(shift_in), .init_n(init_n),
                    .output_on(output_on), .led_sink_o(led_sink_o),
                    .led_sink_oe_n(led_sink_oe_n), .cascade_out(cascade_out));

  //////////////////////////////////////////////////////////////////////////////
  // Compare tasks; the pin synchroniser needs a few cycles, so settle first.
  task automatic settle();
    repeat (6) @(negedge clock);
  endtask
  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_vec({15'h0, got}, {15'h0, exp});
  endtask

  // Host operations with the stored-value model: a high serial bit stores 0.
  task automatic shift(input logic b);
    host.pulse(1'h1, 1'h0, b);
    sr_exp = {sr_exp[14:0], ~b};
  endtask
  task automatic latch();
    host.pulse(1'h0, 1'h1, 1'h0);
    lat_exp = sr_exp;
  endtask
  task automatic tied(input logic b);
    host.pulse(1'h1, 1'h1, b);
    lat_exp = sr_exp;
    sr_exp = {sr_exp[14:0], ~b};
  endtask
  task automatic shift_word(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      shift(w[i]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    settle();
    check_vec(led_sink_oe_n, 16'hFFFF);
    check_vec(led_sink_o, 16'h0000);
    check_bit(cascade_out, 1'h0);
    $display("test reset done");
  endtask
  task automatic t_load();
    shift_word(16'hA5C3);
    settle();
    check_vec(led_sink_oe_n, 16'hFFFF);
    check_bit(cascade_out, 1'h1);
    check_bit(cascade_out, 1'h1);
    latch();
    settle();
    check_vec(led_sink_oe_n, lat_exp);
    check_vec(led_sink_o, 16'h0000);
    check_bit(cascade_out, ~sr_exp[15]);
    $display("test load done");
  endtask
  task automatic t_off();
    host.set_pins(1'h1, 1'h1);
    settle();
    check_vec(led_sink_oe_n, 16'hFFFF);
    shift(1'h0);
    settle();
    check_bit(cascade_out, ~sr_exp[15]);
    host.set_pins(1'h0, 1'h1);
    settle();
    check_vec(led_sink_oe_n, lat_exp);
    latch();
    settle();
    check_vec(led_sink_oe_n, lat_exp);
    $display("test output disable done");
  endtask
  task automatic t_tied();
    shift_word(16'h3C96);
    tied(1'h1);
    settle();
    check_vec(led_sink_oe_n, lat_exp);
    tied(1'h0);
    settle();
    check_vec(led_sink_oe_n, lat_exp);
    $display("test tied clocks done");
  endtask
  task automatic t_init();
    host.set_pins(1'h0, 1'h0);
    settle();
    check_vec(led_sink_oe_n, 16'hFFFF);
    check_bit(cascade_out, 1'h0);
    host.pulse(1'h1, 1'h1, 1'h1);
    host.set_pins(1'h0, 1'h1);
    sr_exp = 16'hFFFF;
    lat_exp = 16'hFFFF;
    settle();
    check_vec(led_sink_oe_n, lat_exp);
    latch();
    settle();
    check_vec(led_sink_oe_n, 16'hFFFF);
    $display("test init done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard; the whole run needs well under 3000 cycles.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Main sequence after four cycles of reset.
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'h1;
    t_reset();
    t_load();
    t_off();
    t_tied();
    t_init();
    wrap_up();
  end
endmodule
